// >>> hw/hcr_config_regs.sv
`timescale 1ns/1ns
module hcr_config_regs (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // serial pins
    input wire logic scl,
    input wire logic sda,
    output logic sda_drv,
    output logic sda_oe,
    input wire logic addr_sel,
    // pin configuration and analogue status
    input wire hcr_pkg::hcr_cfg_s pin_cfg,
    input wire logic [7:0] thermistor_code,
    input wire logic source_below,
    input wire logic battery_over,
    input wire logic battery_under,
    input wire logic energy_ready,
    // active configuration
    output hcr_pkg::hcr_cfg_s cfg_active,
    output logic [1:0] energy_window,
    output logic charge_allow,
    output logic thermal_fault,
    output logic doze_enter,
    output logic event_pin
);
    import hcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detect
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic [1:0] adr_sync; // address strap, two flops

    // two flops per pin, then one delay stage for edges
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
            adr_sync <= 2'h0;
        end
        else
        begin
            scl_m <= scl;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda;
            sda_s <= sda_m;
            sda_d <= sda_s;
            adr_sync <= {adr_sync[0], addr_sel};
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

    ////////////////////////////////////////////////////////////////////////
    // serial slave state machine
    hcr_state_e st_reg, st_next;
    logic [2:0] cnt_reg, cnt_next;     // bit counter
    logic [7:0] sh_reg, sh_next;       // shift register
    logic [7:0] ptr_reg, ptr_next;     // register pointer
    logic first_reg, first_next;       // next byte is the pointer
    logic rw_reg, rw_next;             // read transfer
    logic oe_reg, oe_next;             // pulling data line low
    logic got_reg, got_next;           // eight bits received
    logic more_reg, more_next;         // host acked a read byte
    logic wr_stb, load_rd;
    logic [7:0] rd_data;

    // next state of the slave
    always_comb
    begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        ptr_next = ptr_reg;
        first_next = first_reg;
        rw_next = rw_reg;
        oe_next = oe_reg;
        got_next = got_reg;
        more_next = more_reg;
        wr_stb = 1'b0;
        load_rd = 1'b0;
        if (stop_det)
        begin
            st_next = HCR_IDLE;
            oe_next = 1'b0;
        end
        else if (start_det)
        begin
            // start or repeated start
            st_next = HCR_ADDR;
            cnt_next = 3'h0;
            got_next = 1'b0;
            oe_next = 1'b0;
            first_next = 1'b1;
        end
        else
        begin
            case (st_reg)
                HCR_ADDR, HCR_RX:
                begin
                    if (scl_rise)
                    begin
                        sh_next = {sh_reg[6:0], sda_s};
                        cnt_next = cnt_reg + 3'h1;
                        got_next = (cnt_reg == 3'h7);
                    end
                    else if (scl_fall && got_reg)
                    begin
                        got_next = 1'b0;
                        if (st_reg == HCR_ADDR)
                        begin
                            // answer only our own address
                            if (sh_reg[7:1] == {HCR_DEV_ADDR_HI, adr_sync[1]})
                            begin
                                rw_next = sh_reg[0];
                                oe_next = 1'b1;
                                st_next = HCR_ACK;
                            end
                            else
                            begin
                                st_next = HCR_IDLE;
                            end
                        end
                        else
                        begin
                            oe_next = 1'b1;
                            st_next = HCR_ACK;
                            if (first_reg)
                            begin
                                ptr_next = sh_reg;
                                first_next = 1'b0;
                            end
                            else
                            begin
                                wr_stb = 1'b1;
                                ptr_next = ptr_reg + 8'h01;
                            end
                        end
                    end
                end
                HCR_ACK:
                begin
                    if (scl_fall)
                    begin
                        cnt_next = 3'h0;
                        if (rw_reg)
                        begin
                            load_rd = 1'b1;
                        end
                        else
                        begin
                            oe_next = 1'b0;
                            st_next = HCR_RX;
                        end
                    end
                end
                HCR_TX:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_reg == 3'h7)
                        begin
                            oe_next = 1'b0;
                            st_next = HCR_RACK;
                        end
                        else
                        begin
                            sh_next = {sh_reg[6:0], 1'b0};
                            oe_next = ~sh_reg[6];
                            cnt_next = cnt_reg + 3'h1;
                        end
                    end
                end
                HCR_RACK:
                begin
                    if (scl_rise)
                    begin
                        more_next = ~sda_s;
                    end
                    else if (scl_fall)
                    begin
                        cnt_next = 3'h0;
                        if (more_reg)
                        begin
                            load_rd = 1'b1;
                        end
                        else
                        begin
                            st_next = HCR_IDLE;
                        end
                    end
                end
                default:
                begin
                    st_next = HCR_IDLE;
                end
            endcase
        end
        if (load_rd)
        begin
            sh_next = rd_data;
            oe_next = ~rd_data[7];
            ptr_next = ptr_reg + 8'h01;
            st_next = HCR_TX;
        end
    end

    // slave registers
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            st_reg <= HCR_IDLE;
            cnt_reg <= 3'h0;
            sh_reg <= 8'h00;
            ptr_reg <= 8'h00;
            first_reg <= 1'b1;
            rw_reg <= 1'b0;
            oe_reg <= 1'b0;
            got_reg <= 1'b0;
            more_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            ptr_reg <= ptr_next;
            first_reg <= first_next;
            rw_reg <= rw_next;
            oe_reg <= oe_next;
            got_reg <= got_next;
            more_reg <= more_next;
        end
    end

    assign sda_drv = 1'b0;
    assign sda_oe = oe_reg;

    ////////////////////////////////////////////////////////////////////////
    // configuration, event and status registers
    hcr_cfg_s ser_reg, ser_next;       // serially written copy
    hcr_cfg_s work_reg, work_next;     // working system copy
    hcr_cfg_s act_reg, act_next;       // active configuration
    logic [5:0] even_reg, even_next;   // event enables
    logic [5:0] flag_reg, flag_next;   // sticky event flags
    logic load_reg, load_next;         // use serial configuration
    logic pend_reg, pend_next;         // copy to working pending
    logic rdy_reg, rdy_next;           // serial ready seen
    logic fault_reg, fault_next;
    logic src_reg, over_reg, under_reg;
    logic chg_reg, chg_next, doze_reg, doze_next;
    logic [1:0] win_reg, win_next;
    logic [5:0] ev;

    // requested window code, shortened where its double exceeds the tracking period
    function automatic logic [1:0] fix_window(input logic [2:0] tim,
                                              input logic [1:0] win);
        logic [1:0] need;
        logic [1:0] w;
        need = HCR_WIN_128;
        w = (win > HCR_WIN_32) ? HCR_WIN_32 : win;
        if (tim == HCR_TIM_P64)
        begin
            need = HCR_WIN_32;
        end
        else if (tim == HCR_TIM_P128)
        begin
            need = HCR_WIN_64;
        end
        fix_window = (w > need) ? w : need;
    endfunction : fix_window

    // next values of the register bank
    always_comb
    begin
        ser_next = ser_reg;
        work_next = work_reg;
        even_next = even_reg;
        load_next = load_reg;
        pend_next = pend_reg;
        rdy_next = 1'b1;
        if (pend_reg)
        begin
            // copy serial set to working set
            work_next = ser_reg;
            pend_next = 1'b0;
        end
        if (wr_stb)
        begin
            case (ptr_reg)
                HCR_OFS_PEAK: {ser_next.timing, ser_next.ratio} = sh_reg[6:0];
                HCR_OFS_UNDER: ser_next.under = sh_reg;
                HCR_OFS_OVER: ser_next.over = sh_reg;
                HCR_OFS_COLD: ser_next.cold = sh_reg;
                HCR_OFS_HOT: ser_next.hot = sh_reg;
                HCR_OFS_PWR: ser_next.power_settings = sh_reg[3:0];
                HCR_OFS_DOZE: ser_next.doze = sh_reg[3:0];
                HCR_OFS_ADC: ser_next.adc_rate = sh_reg[2:0];
                HCR_OFS_METER: ser_next.meter = sh_reg[3:0];
                HCR_OFS_EVEN: even_next = sh_reg[5:0];
                HCR_OFS_CTRL: load_next = sh_reg[HCR_CTRL_LOAD];
                default: ;
            endcase
            // any write other than to CTRL resyncs while in serial mode; a CTRL write resyncs only when it sets the load bit
            pend_next = (ptr_reg == HCR_OFS_CTRL) ? sh_reg[HCR_CTRL_LOAD]
                                                  : (load_reg | pend_next);
        end
        act_next = load_reg ? work_reg : pin_cfg;
        win_next = fix_window(act_reg.timing, act_reg.meter[3:2]);
        fault_next = act_reg.power_settings[HCR_PWR_THERMAL] &
                     ((thermistor_code > act_reg.cold) |
                      (thermistor_code < act_reg.hot));
        // inhibit bit and thermal fault stop charging
        chg_next = ~act_reg.power_settings[HCR_PWR_INHIBIT] & ~fault_reg;
        doze_next = act_reg.doze[HCR_DOZE_EN] & source_below;
        ev[HCR_EV_ENERGY] = energy_ready & act_reg.meter[HCR_METER_EN];
        ev[HCR_EV_TEMP] = fault_next ^ fault_reg;
        ev[HCR_EV_SRCLOW] = source_below ^ src_reg;
        ev[HCR_EV_OVER] = battery_over ^ over_reg;
        ev[HCR_EV_UNDER] = battery_under ^ under_reg;
        ev[HCR_EV_READY] = ~rdy_reg;
        // read of the flag register clears, new events win
        flag_next = (load_rd && ptr_reg == HCR_OFS_FLAG) ? 6'h00 : flag_reg;
        // set only through an enable already set
        flag_next = flag_next | (ev & even_reg);
    end

    // bank registers
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            ser_reg <= HCR_RST_CFG;
            work_reg <= HCR_RST_CFG;
            act_reg <= HCR_RST_CFG;
            even_reg <= HCR_RST_EVEN;
            flag_reg <= 6'h00;
            load_reg <= 1'b0;
            pend_reg <= 1'b0;
            rdy_reg <= 1'b0;
            fault_reg <= 1'b0;
            src_reg <= 1'b0;
            over_reg <= 1'b0;
            under_reg <= 1'b0;
            chg_reg <= 1'b0;
            doze_reg <= 1'b0;
            win_reg <= HCR_WIN_128;
        end
        else
        begin
            ser_reg <= ser_next;
            work_reg <= work_next;
            act_reg <= act_next;
            even_reg <= even_next;
            flag_reg <= flag_next;
            load_reg <= load_next;
            pend_reg <= pend_next;
            rdy_reg <= rdy_next;
            fault_reg <= fault_next;
            src_reg <= source_below;
            over_reg <= battery_over;
            under_reg <= battery_under;
            chg_reg <= chg_next;
            doze_reg <= doze_next;
            win_reg <= win_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read multiplexer, unused bits and offsets read zero
    always_comb
    begin
        rd_data = HCR_RST_BYTE;
        case (ptr_reg)
            HCR_OFS_PEAK: rd_data = {1'b0, ser_reg.timing, ser_reg.ratio};
            HCR_OFS_UNDER: rd_data = ser_reg.under;
            HCR_OFS_OVER: rd_data = ser_reg.over;
            HCR_OFS_COLD: rd_data = ser_reg.cold;
            HCR_OFS_HOT: rd_data = ser_reg.hot;
            HCR_OFS_PWR: rd_data = {4'h0, ser_reg.power_settings};
            HCR_OFS_DOZE: rd_data = {4'h0, ser_reg.doze};
            HCR_OFS_ADC: rd_data = {5'h00, ser_reg.adc_rate};
            HCR_OFS_METER: rd_data = {4'h0, ser_reg.meter};
            HCR_OFS_EVEN: rd_data = {2'h0, even_reg};
            HCR_OFS_CTRL: rd_data = {5'h00, load_reg & ~pend_reg, 1'b0,
                                     load_reg};
            HCR_OFS_FLAG: rd_data = {2'h0, flag_reg};
            HCR_OFS_STAT: rd_data = {1'b0, chg_reg, 1'b0, fault_reg,
                                     src_reg, over_reg, under_reg, 1'b0};
            default: rd_data = HCR_RST_BYTE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign cfg_active = act_reg;
    assign energy_window = win_reg;
    assign charge_allow = chg_reg;
    assign thermal_fault = fault_reg;
    assign doze_enter = doze_reg;
    // event pin high while any flag stands
    assign event_pin = |flag_reg;

endmodule : hcr_config_regs

// >>> hw/hcr_pkg.sv
package hcr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] HCR_OFS_PEAK = 8'h01;
    localparam logic [7:0] HCR_OFS_UNDER = 8'h02;
    localparam logic [7:0] HCR_OFS_OVER = 8'h03;
    localparam logic [7:0] HCR_OFS_COLD = 8'h04;
    localparam logic [7:0] HCR_OFS_HOT = 8'h05;
    localparam logic [7:0] HCR_OFS_PWR = 8'h06;
    localparam logic [7:0] HCR_OFS_DOZE = 8'h07;
    localparam logic [7:0] HCR_OFS_ADC = 8'h08;
    localparam logic [7:0] HCR_OFS_METER = 8'h09;
    localparam logic [7:0] HCR_OFS_EVEN = 8'h0A;
    localparam logic [7:0] HCR_OFS_CTRL = 8'h0B;
    localparam logic [7:0] HCR_OFS_FLAG = 8'h0C;
    localparam logic [7:0] HCR_OFS_STAT = 8'h0D;

    ////////////////////////////////////////////////////////////////////////
    // serial address: upper six bits fixed, lowest bit from a pin
    localparam logic [5:0] HCR_DEV_ADDR_HI = 6'h20;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int HCR_PWR_INHIBIT = 3;
    localparam int HCR_PWR_THERMAL = 2;
    localparam int HCR_PWR_HIPOWER = 1;
    localparam int HCR_PWR_BATCORE = 0;
    localparam int HCR_DOZE_EN = 0;
    localparam int HCR_METER_MODE = 1;
    localparam int HCR_METER_EN = 0;
    localparam int HCR_CTRL_LOAD = 0;
    localparam int HCR_CTRL_SYNCED = 2;
    localparam int HCR_EV_ENERGY = 5;
    localparam int HCR_EV_TEMP = 4;
    localparam int HCR_EV_SRCLOW = 3;
    localparam int HCR_EV_OVER = 2;
    localparam int HCR_EV_UNDER = 1;
    localparam int HCR_EV_READY = 0;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [3:0] HCR_RST_PWR = 4'h7;
    localparam logic [3:0] HCR_RST_DOZE = 4'h1;
    localparam logic [3:0] HCR_RST_METER = 4'h0;
    localparam logic [5:0] HCR_RST_EVEN = 6'h01;
    localparam logic [7:0] HCR_RST_BYTE = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // energy window codes: 128 ms, 64 ms, 32 ms
    localparam logic [1:0] HCR_WIN_128 = 2'h0;
    localparam logic [1:0] HCR_WIN_64 = 2'h1;
    localparam logic [1:0] HCR_WIN_32 = 2'h2;
    // tracking timing codes whose period is 64 ms and 128 ms
    localparam logic [2:0] HCR_TIM_P64 = 3'h0;
    localparam logic [2:0] HCR_TIM_P128 = 3'h5;

    ////////////////////////////////////////////////////////////////////////
    // full configuration set
    typedef struct packed {
        logic [2:0] timing;
        logic [3:0] ratio;
        logic [7:0] under;
        logic [7:0] over;
        logic [7:0] cold;
        logic [7:0] hot;
        logic [3:0] power_settings;
        logic [3:0] doze;
        logic [2:0] adc_rate;
        logic [3:0] meter;
    } hcr_cfg_s;

    localparam hcr_cfg_s HCR_RST_CFG = '{
        timing: 3'h0, ratio: 4'h0, under: 8'h00, over: 8'h00,
        cold: 8'h00, hot: 8'h00, power_settings: HCR_RST_PWR, doze: HCR_RST_DOZE,
        adc_rate: 3'h0, meter: HCR_RST_METER};

    // serial slave states
    typedef enum logic [6:0] {
        HCR_IDLE = 7'h01,
        HCR_ADDR = 7'h02,
        HCR_RX = 7'h04,
        HCR_ACK = 7'h08,
        HCR_TX = 7'h10,
        HCR_RACK = 7'h20,
        HCR_SPARE = 7'h40
    } hcr_state_e;

endpackage : hcr_pkg

// >>> bench/hcr_props.sv
`timescale 1ns/1ns
module hcr_props (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // analogue levels
    input wire logic [7:0] thermistor_code,
    input wire logic source_below,
    // watched outputs
    input wire hcr_pkg::hcr_cfg_s cfg_active,
    input wire logic [1:0] energy_window,
    input wire logic charge_allow,
    input wire logic thermal_fault,
    input wire logic doze_enter,
    input wire logic event_pin
);
    import hcr_pkg::*;
    ////////////////////////////////////////
    logic [2:0] up_cnt; // cycles since reset
    wire logic live = (up_cnt == 3'h4); // registered outputs settled
    wire logic watch = live && cfg_active.power_settings[HCR_PWR_THERMAL]; // watch on
    logic out_rng; // code outside hot..cold
    assign out_rng = (thermistor_code > cfg_active.cold)
        || (thermistor_code < cfg_active.hot);
    // settle counter, saturates at four
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            up_cnt <= 3'h0;
        else if (!live)
            up_cnt <= up_cnt + 3'h1;
    end
    // window clamped to half the tracking period
    function automatic logic [1:0] win_exp(input hcr_cfg_s c);
        logic [1:0] w;
        w = (c.meter[3:2] == 2'h3) ? HCR_WIN_32 : c.meter[3:2];
        if (c.timing == HCR_TIM_P64)
            w = HCR_WIN_32;
        else if ((c.timing == HCR_TIM_P128) && (w == HCR_WIN_128))
            w = HCR_WIN_64;
        return w;
    endfunction : win_exp
    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    property p_rst_cfg;
        $rose(resetn) |-> (cfg_active == HCR_RST_CFG);
    endproperty
    a_rst_cfg: assert property (p_rst_cfg) else $error("no reset");
    property p_ready_pin;
        $rose(resetn) |-> ##[1:4] event_pin;
    endproperty
    a_ready_pin: assert property (p_ready_pin) else $error("silent");
    property p_win;
        (live && $stable(cfg_active))[*3] |->
            (energy_window == win_exp(cfg_active));
    endproperty
    a_win: assert property (p_win) else $error("bad window");
    property p_inhibit;
        (live && cfg_active.power_settings[HCR_PWR_INHIBIT])[*3] |-> !charge_allow;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("charge on");
    property p_watch_off;
        (live && !cfg_active.power_settings[HCR_PWR_THERMAL])[*3] |-> !thermal_fault;
    endproperty
    a_watch_off: assert property (p_watch_off) else $error("fault");
    property p_too_far;
        (watch && out_rng)[*3] |-> thermal_fault;
    endproperty
    a_too_far: assert property (p_too_far) else $error("no fault");
    property p_in_range;
        (watch && !out_rng)[*3] |-> !thermal_fault;
    endproperty
    a_in_range: assert property (p_in_range) else $error("fault");
    property p_doze_on;
        (live && cfg_active.doze[HCR_DOZE_EN] && source_below)[*3]
            |-> doze_enter;
    endproperty
    a_doze_on: assert property (p_doze_on) else $error("no doze");
    property p_doze_off;
        (live && !cfg_active.doze[HCR_DOZE_EN])[*3] |-> !doze_enter;
    endproperty
    a_doze_off: assert property (p_doze_off) else $error("doze");
endmodule : hcr_props

// >>> bench/hcr_host.sv
`timescale 1ns/1ns
module hcr_host #(
    parameter int HALF = 63 // clocks per scl phase, near 1 MHz
) (
    // clock and bus lines
    input wire logic clock,
    input wire logic sda_line,
    input wire logic event_pin,
    // driven lines, high means released
    output logic scl,
    output logic sda
);
    // bus idles released
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task automatic wait_ready;
        for (int i = 0; (i < 64) && (event_pin !== 1'b1); i++)
            tick(1);
    endtask : wait_ready
    // start (1 then 0) or stop (0 then 1) while scl high
    task automatic cond(input logic a, input logic b);
        tick(8);
        sda = a;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda = b;
        tick(HALF);
        scl = b;
    endtask : cond
    // one bit, line sampled at end of high phase
    task automatic bit_io(input logic b, output logic s);
        tick(8);
        sda = b;
        tick(HALF - 8);
        scl = 1'b1;
        tick(HALF);
        s = sda_line;
        scl = 1'b0;
    endtask : bit_io
    // eight bits msb first, then the ack slot
    task automatic byte_io(input logic [7:0] d, input logic nk,
        output logic [7:0] q, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], s);
            q[i] = s;
        end
        bit_io(nk, s);
        ack = ~s;
    endtask : byte_io
    task automatic write_regs(input logic [6:0] dev, input logic [7:0] p,
        input logic [7:0] d[$], output logic ok);
        logic [7:0] q;
        logic a;
        cond(1'b1, 1'b0);
        byte_io({dev, 1'b0}, 1'b1, q, ok);
        byte_io(p, 1'b1, q, a);
        foreach (d[i])
        begin
            byte_io(d[i], 1'b1, q, a);
            ok = ok & a;
        end
        cond(1'b0, 1'b1);
    endtask : write_regs
    task automatic read_regs(input logic [6:0] dev, input logic [7:0] p,
        input int n, output logic [7:0] q[$]);
        logic [7:0] b;
        logic a;
        q = {};
        cond(1'b1, 1'b0);
        byte_io({dev, 1'b0}, 1'b1, b, a);
        byte_io(p, 1'b1, b, a);
        cond(1'b1, 1'b0);
        byte_io({dev, 1'b1}, 1'b1, b, a);
        for (int i = 0; i < n; i++)
        begin
            byte_io(8'hFF, i == n - 1, b, a);
            q.push_back(b);
        end
        cond(1'b0, 1'b1);
    endtask : read_regs
endmodule : hcr_host

// >>> bench/test_harvester_config_registers.sv
`timescale 1ns/1ns
module test_harvester_config_registers;
    import hcr_pkg::*;
    logic clock, resetn, scl, host_sda, sda_line, sda_drv, sda_oe;
    logic addr_sel, source_below, battery_over, battery_under;
    logic energy_ready, charge_allow, thermal_fault, doze_enter, event_pin;
    logic [7:0] thermistor_code;
    logic [1:0] energy_window;
    hcr_cfg_s pin_cfg, cfg_active;
    int n_errors = 0, check_count = 0, cycles = 0;
    // open drain line with pull-up
    assign sda_line = host_sda & (sda_drv | ~sda_oe);
    wire logic [6:0] dev = {6'h20, addr_sel};
    hcr_config_regs u_dut (.clock(clock), .resetn(resetn), .scl(scl),
        .sda(sda_line), .sda_drv(sda_drv), .sda_oe(sda_oe),
        .addr_sel(addr_sel), .pin_cfg(pin_cfg),
        .thermistor_code(thermistor_code), .source_below(source_below),
        .battery_over(battery_over), .battery_under(battery_under),
        .energy_ready(energy_ready), .cfg_active(cfg_active),
        .energy_window(energy_window), .charge_allow(charge_allow),
        .thermal_fault(thermal_fault), .doze_enter(doze_enter),
        .event_pin(event_pin));
    hcr_host u_host (.clock(clock), .sda_line(sda_line),
        .event_pin(event_pin), .scl(scl), .sda(host_sda));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
        logic ok;
        u_host.write_regs(dev, p, d, ok);
        check(64'(ok), 64'h1);
    endtask : wr
    task automatic rd_cmp(input logic [7:0] p, input logic [7:0] e[$]);
        logic [7:0] q[$];
        u_host.read_regs(dev, p, e.size(), q);
        foreach (e[i])
            check(64'(q[i]), 64'(e[i]));
    endtask : rd_cmp
    task automatic t_reset;
        check(64'(cfg_active), 64'(pin_cfg));
        rd_cmp(HCR_OFS_PWR, {8'h07, 8'h01, 8'h00, 8'h00, 8'h01});
        rd_cmp(HCR_OFS_FLAG, {8'h01});
        check(64'(event_pin), 64'h0);
    endtask : t_reset
    // junk in unused bits, then load the serial set
    task automatic t_config;
        wr(HCR_OFS_PEAK, {8'h85, 8'hA5, 8'h5A, 8'hC0, 8'h40, 8'hF6,
            8'hFB, 8'hFC, 8'hF3, 8'hE1, 8'h01});
        rd_cmp(HCR_OFS_PEAK, {8'h05, 8'hA5, 8'h5A, 8'hC0, 8'h40, 8'h06,
            8'h0B, 8'h04, 8'h03, 8'h21});
        check(64'(cfg_active), 64'({3'h0, 4'h5, 8'hA5, 8'h5A, 8'hC0,
            8'h40, 4'h6, 4'hB, 3'h4, 4'h3}));
        check(64'(energy_window), 64'(HCR_WIN_32));
        check(64'({thermal_fault, charge_allow, doze_enter}), 64'h3);
    endtask : t_config
    task automatic t_power;
        thermistor_code = 8'h20;
        wr(HCR_OFS_PWR, {8'h08});
        check(64'({thermal_fault, charge_allow}), 64'h0);
        wr(HCR_OFS_PWR, {8'h04});
        check(64'({thermal_fault, charge_allow}), 64'h2);
        wr(HCR_OFS_PWR, {8'h00, 8'h0A});
        check(64'({thermal_fault, charge_allow, doze_enter}), 64'h2);
        wr(HCR_OFS_PEAK, {8'h50});
        check(64'(energy_window), 64'(HCR_WIN_64));
    endtask : t_power
    task automatic t_events;
        for (int k = 0; k < 2; k++)
        begin
            wr(HCR_OFS_EVEN, {(k == 1) ? 8'h20 : 8'h01});
            energy_ready = 1'b1;
            @(negedge clock);
            energy_ready = 1'b0;
            repeat (8) @(negedge clock);
            check(64'(event_pin), 64'(k));
        end
        rd_cmp(HCR_OFS_FLAG, {8'h20});
        check(64'(event_pin), 64'h0);
    endtask : t_events
    task automatic t_refuse;
        logic ok;
        u_host.write_regs({6'h20, ~addr_sel}, HCR_OFS_PWR, {8'h0F}, ok);
        check(64'(ok), 64'h0);
        check(64'(cfg_active.power_settings), 64'h0);
        wr(8'h20, {8'h55});
        rd_cmp(8'h20, {8'h00});
    endtask : t_refuse
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, n_errors);
        if ((n_errors == 0) && (check_count > 0))
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 99000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial
    begin
        {resetn, addr_sel, battery_over, battery_under} = 4'h0;
        {energy_ready, source_below} = 2'h1;
        thermistor_code = 8'h80;
        pin_cfg = hcr_cfg_s'(54'h15A5A5A5A5A5A5);
        repeat (12) @(negedge clock);
        resetn = 1'b1;
        u_host.wait_ready();
        t_reset();
        t_config();
        t_power();
        t_events();
        t_refuse();
        tally_and_finish();
    end
endmodule : test_harvester_config_registers
bind hcr_config_regs hcr_props u_props (.clock(clock), .resetn(resetn),
    .thermistor_code(thermistor_code), .source_below(source_below),
    .cfg_active(cfg_active), .energy_window(energy_window),
    .charge_allow(charge_allow), .thermal_fault(thermal_fault),
    .doze_enter(doze_enter), .event_pin(event_pin));
